// >>> verilog/dpa_rx_regs.svh
// Function
// RULE_01 - Eight equally spaced phases of one fast clock, tapped from a four-stage differential ring, reach every receive channel.
// RULE_02 - Each channel picks the phase nearest the data and hands retimed data plus that phase to its deserializer; code routes the phase to phase_o.
// RULE_03 - Phase selection runs on its own and without pause per channel, and channels may settle on different phases.
// RULE_04 - Selection steps are one eighth of a unit interval, 125 ps at 1 Gbps.
// RULE_05 - On every rising fast-clock edge the selector measures the clock-to-data offset and steps to cancel it.
// RULE_06 - The forwarded clock enters on a dedicated input and is multiplied up to the serial bit rate; the code takes clk_link_i already multiplied.
// RULE_07 - The transmitter locks the channel with a transition-rich pattern such as ten zeros then ten ones, 256 times.
// RULE_08 - Other training patterns are 00001111, 10010000, 10101010 or 01010101, with lock time depending on the pattern.
// RULE_09 - Each channel has its own synchronizer moving its parallel words onto the shared fabric clock.
// RULE_10 - The synchronizer is a FIFO four entries deep and one word wide, written on the parallel side and read on the fabric clock.
// RULE_11 - Parallel and fabric clocks share one frequency, so the FIFO neither fills nor drains in normal use.
// RULE_12 - A channel sustains 1000 Mbps with phase alignment and 840 Mbps without it.
// RULE_13 - With phase alignment the deserialization factor is 8 or 10 bits per word.
// RULE_14 - The deserializer shifts in one serial bit on every falling edge of the fast clock.
// RULE_15 - A load strobe moves the shift register into the parallel register on the third falling edge.
// RULE_16 - After reset the synchronizer read side starts two entries behind the write side.
`ifndef DPA_RX_REGS_SVH
`define DPA_RX_REGS_SVH

`define DPA_PHASES 8
`define DPA_RING_STAGES 4
`define DPA_STEP_PS 125
`define DPA_RATE_MBPS 1000
`define DPA_RATE_NO_ALIGN_MBPS 840
`define DPA_CLK_MULT 10
`define DPA_WORD_NARROW 8
`define DPA_WORD_WIDE 10
`define DPA_LOAD_EDGE 4'h2
`define DPA_FIFO_DEPTH 4
`define DPA_FIFO_PRIME 2
`define DPA_LOCK_CYCLES 5'h10
`define DPA_SYS_PERIOD_NS 20

`endif

// >>> verilog/dpa_rx_pkg.sv
package dpa_rx_pkg;
  typedef logic [2:0] phase_t;
  typedef logic [9:0] word_t;
  typedef struct packed {
    logic wide;
    word_t bits;
  } rx_word_t;
endpackage

// >>> verilog/phase_selector.sv
`timescale 1ns/1ps
`include "dpa_rx_regs.svh"

module phase_selector (
  input wire logic clk_link_i,
  input wire logic rst_i,
  input wire logic [3:0] stage_true_i,
  input wire logic [3:0] stage_comp_i,
  input wire logic enable_i,
  output dpa_rx_pkg::phase_t phase_o,
  output logic bit_o,
  output logic locked_o
);

  typedef struct packed {
    dpa_rx_pkg::phase_t sel;
    logic data;
    logic [4:0] stable;
    logic locked;
    logic last7;
  } sel_state_t;

  sel_state_t q;
  sel_state_t d;
  logic [7:0] taps;

  // RULE_01 - ring taps spaced
  // True and complement outputs of each stage give phases g and g+4
  for (genvar g = 0; g < `DPA_RING_STAGES; g++) begin : g_tap
    assign taps[g] = stage_true_i[g];
    assign taps[g + `DPA_RING_STAGES] = stage_comp_i[g];
  end

  always_comb begin
    logic found;
    logic [8:0] ext;
    dpa_rx_pkg::phase_t edge_at;
    dpa_rx_pkg::phase_t diff;
    found = 1'b0;
    ext = {taps, q.last7};
    edge_at = 3'h0;
    diff = 3'h0;
    d = q;
    // RULE_05 - measure offset per edge
    // Tap 0 is compared with tap 7 of the previous edge, its neighbour in
    // time; tap 7 of the same edge lies seven eighths of a bit later.
    for (int k = 0; k < `DPA_PHASES; k++) begin
      if (!found && ext[k + 1] != ext[k]) begin
        found = 1'b1;
        edge_at = 3'(k);
      end
    end
    // RULE_02 - aim mid eye
    diff = 3'(edge_at + 3'h4 - q.sel);
    if (!enable_i) begin
      d.sel = 3'h0;
      d.stable = 5'h00;
    // RULE_04 - one eighth UI step
    end else if (found && diff != 3'h0) begin
      d.sel = diff[2] ? 3'(q.sel - 3'h1) : 3'(q.sel + 3'h1);
      d.stable = 5'h00;
    end else if (q.stable != `DPA_LOCK_CYCLES) begin
      d.stable = 5'(q.stable + 5'h01);
    end
    d.locked = enable_i && (q.stable == `DPA_LOCK_CYCLES);
    // RULE_02 - retimed bit
    d.data = taps[q.sel];
    d.last7 = taps[7];
  end

  // RULE_03 - free running tracking
  always_ff @(posedge clk_link_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign phase_o = q.sel;
  assign bit_o = q.data;
  assign locked_o = q.locked;

endmodule

// >>> verilog/word_sync_fifo.sv
`timescale 1ns/1ps
`include "dpa_rx_regs.svh"

module word_sync_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = `DPA_FIFO_DEPTH,
  parameter int PRIME = `DPA_FIFO_PRIME
) (
  input wire logic wr_clk_i,
  input wire logic wr_rst_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic rd_clk_i,
  input wire logic rd_rst_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] rg_s1;
    logic [AW:0] rg_s2;
  } wr_state_t;

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] wg_s1;
    logic [AW:0] wg_s2;
    logic primed;
  } rd_state_t;

  logic [WIDTH-1:0] mem [DEPTH];
  wr_state_t wq;
  wr_state_t wd;
  rd_state_t rq;
  rd_state_t rd;
  logic [AW:0] wgray;
  logic [AW:0] rgray;
  logic [AW:0] wbin_rd;
  logic [AW:0] level;

  assign wgray = wq.bin ^ (wq.bin >> 1);
  assign rgray = rq.bin ^ (rq.bin >> 1);
  // Full only from the synchronised read pointer, never the raw one
  assign wr_ready_o = wgray != {~wq.rg_s2[AW:AW-1], wq.rg_s2[AW-2:0]};

  always_comb begin
    wd = wq;
    wd.rg_s1 = rgray;
    wd.rg_s2 = wq.rg_s1;
    if (wr_valid_i && wr_ready_o) begin
      wd.bin = (AW+1)'(wq.bin + 1'b1);
    end
  end

  always_comb begin
    wbin_rd = '0;
    wbin_rd[AW] = rq.wg_s2[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      wbin_rd[i] = wbin_rd[i + 1] ^ rq.wg_s2[i];
    end
  end

  assign level = wbin_rd - rq.bin;
  // RULE_16 - read lags two entries
  assign rd_valid_o = rq.primed && level != '0;
  assign rd_data_o = mem[rq.bin[AW-1:0]];

  always_comb begin
    rd = rq;
    rd.wg_s1 = wgray;
    rd.wg_s2 = rq.wg_s1;
    if (level >= (AW+1)'(PRIME)) begin
      rd.primed = 1'b1;
    end
    if (rd_valid_o && rd_ready_i) begin
      rd.bin = (AW+1)'(rq.bin + 1'b1);
    end
  end

  // RULE_10 - written on parallel side
  always_ff @(posedge wr_clk_i) begin
    if (wr_valid_i && wr_ready_o) begin
      mem[wq.bin[AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
    if (wr_rst_i) begin
      wq <= '0;
    end else begin
      wq <= wd;
    end
  end

  // RULE_10 - read on fabric clock
  always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
    if (rd_rst_i) begin
      rq <= '0;
    end else begin
      rq <= rd;
    end
  end

endmodule

// >>> verilog/dynamic_phase_align_rx.sv
`timescale 1ns/1ps
`include "dpa_rx_regs.svh"

module dynamic_phase_align_rx (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_link_i,
  input wire logic [3:0] stage_true_i,
  input wire logic [3:0] stage_comp_i,
  input wire logic dynamic_phase_alignment_i,
  input wire logic word10_i,
  input wire logic word_ready_i,
  output dpa_rx_pkg::rx_word_t word_o,
  output logic word_valid_o,
  output dpa_rx_pkg::phase_t phase_o,
  output logic locked_o,
  output logic overrun_o
);

  localparam int FW = $bits(dpa_rx_pkg::rx_word_t);

  // Fast clock side, rising edge
  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic w10_s1;
    logic w10_s2;
    logic [3:0] st_s1;
    logic [3:0] st_s2;
    logic [3:0] sc_s1;
    logic [3:0] sc_s2;
    dpa_rx_pkg::phase_t ph_gray;
    logic locked;
    logic overrun;
  } link_state_t;

  // Fast clock side, falling edge
  typedef struct packed {
    logic [9:0] shift;
    logic [3:0] cnt;
    logic rx_parallel_load_strobe;
    dpa_rx_pkg::rx_word_t par;
  } deser_state_t;

  // Shared fabric clock side
  typedef struct packed {
    dpa_rx_pkg::phase_t ph_s1;
    dpa_rx_pkg::phase_t ph_s2;
    dpa_rx_pkg::phase_t phase;
    logic lk_s1;
    logic lk_s2;
    logic locked;
    logic ov_s1;
    logic ov_s2;
    logic overrun;
    dpa_rx_pkg::rx_word_t word;
    logic valid;
  } sys_state_t;

  link_state_t lq;
  link_state_t ld;
  deser_state_t nq;
  deser_state_t nd;
  sys_state_t sq;
  sys_state_t sd;
  logic [1:0] link_rst_q;
  logic link_rst;
  logic [1:0] sys_rst_q;
  logic sys_rst;
  dpa_rx_pkg::phase_t sel_phase;
  logic sel_bit;
  logic sel_locked;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  dpa_rx_pkg::rx_word_t fifo_rd_data;

  // Reset asserts at once, releases on the fast clock
  always_ff @(posedge clk_link_i or posedge rst_i) begin
    if (rst_i) begin
      link_rst_q <= 2'b11;
    end else begin
      link_rst_q <= {link_rst_q[0], 1'b0};
    end
  end

  assign link_rst = link_rst_q[1];

  // Fabric side leaves reset on its own clock, so the FIFO read side and
  // the output registers all start on the same edge
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sys_rst_q <= 2'h3;
    end else begin
      sys_rst_q <= {sys_rst_q[0], 1'h0};
    end
  end

  assign sys_rst = sys_rst_q[1];

  // RULE_06 - multiplied clock in
  // The fast clock arrives already multiplied by the clock multiplier;
  // everything below it only ever sees the bit-rate edge.
  always_comb begin
    ld = lq;
    ld.en_s1 = dynamic_phase_alignment_i;
    ld.en_s2 = lq.en_s1;
    ld.w10_s1 = word10_i;
    ld.w10_s2 = lq.w10_s1;
    ld.st_s1 = stage_true_i;
    ld.st_s2 = lq.st_s1;
    ld.sc_s1 = stage_comp_i;
    ld.sc_s2 = lq.sc_s1;
    // Phase moves one step at a time, so its gray code crosses cleanly;
    // only the jump to phase 0 on alignment off may show one odd sample
    ld.ph_gray = sel_phase ^ (sel_phase >> 1);
    ld.locked = sel_locked;
    // Sticky until reset: a lost word means the clocks are not locked
    if (nq.rx_parallel_load_strobe && !fifo_wr_ready) begin
      ld.overrun = 1'b1;
    end
  end

  always_ff @(posedge clk_link_i or posedge link_rst) begin
    if (link_rst) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // RULE_03 - channel owns selector
  phase_selector phase_selector_inst (
    .clk_link_i(clk_link_i),
    .rst_i(link_rst),
    .stage_true_i(lq.st_s2),
    .stage_comp_i(lq.sc_s2),
    .enable_i(lq.en_s2),
    .phase_o(sel_phase),
    .bit_o(sel_bit),
    .locked_o(sel_locked)
  );

  always_comb begin
    logic [3:0] last;
    last = lq.w10_s2 ? 4'(`DPA_WORD_WIDE - 1) : 4'(`DPA_WORD_NARROW - 1);
    nd = nq;
    // RULE_12 - one bit per edge
    // RULE_14 - shift on falling edge
    nd.shift = {nq.shift[8:0], sel_bit};
    // RULE_13 - factor 8 or 10
    nd.cnt = (nq.cnt >= last) ? 4'h0 : 4'(nq.cnt + 4'h1);
    nd.rx_parallel_load_strobe = 1'b0;
    // RULE_15 - load on third edge
    if (nq.cnt == `DPA_LOAD_EDGE) begin
      nd.rx_parallel_load_strobe = 1'b1;
      nd.par.wide = lq.w10_s2;
      nd.par.bits = lq.w10_s2 ? nq.shift : {2'h0, nq.shift[7:0]};
    end
  end

  always_ff @(negedge clk_link_i or posedge link_rst) begin
    if (link_rst) begin
      nq <= '0;
    end else begin
      nq <= nd;
    end
  end

  // RULE_09 - per channel synchronizer
  // The strobe stands one full fast period, so exactly one rising edge
  // takes each parallel word; the word itself holds for a whole frame.
  // RULE_11 - flags kept as guard
  word_sync_fifo #(
    .WIDTH(FW),
    .DEPTH(`DPA_FIFO_DEPTH),
    .PRIME(`DPA_FIFO_PRIME)
  ) word_sync_fifo_inst (
    .wr_clk_i(clk_link_i),
    .wr_rst_i(link_rst),
    .wr_valid_i(nq.rx_parallel_load_strobe),
    .wr_ready_o(fifo_wr_ready),
    .wr_data_i(nq.par),
    .rd_clk_i(clk_sys_i),
    .rd_rst_i(sys_rst),
    .rd_valid_o(fifo_rd_valid),
    .rd_ready_i(fifo_rd_ready),
    .rd_data_o(fifo_rd_data)
  );

  assign fifo_rd_ready = !sq.valid || word_ready_i;

  always_comb begin
    dpa_rx_pkg::phase_t bin;
    bin = 3'h0;
    sd = sq;
    sd.ph_s1 = lq.ph_gray;
    sd.ph_s2 = sq.ph_s1;
    bin[2] = sq.ph_s2[2];
    bin[1] = bin[2] ^ sq.ph_s2[1];
    bin[0] = bin[1] ^ sq.ph_s2[0];
    sd.phase = bin;
    sd.lk_s1 = lq.locked;
    sd.lk_s2 = sq.lk_s1;
    sd.locked = sq.lk_s2;
    sd.ov_s1 = lq.overrun;
    sd.ov_s2 = sq.ov_s1;
    sd.overrun = sq.ov_s2;
    if (fifo_rd_valid && fifo_rd_ready) begin
      sd.word = fifo_rd_data;
      sd.valid = 1'b1;
    end else if (word_ready_i) begin
      sd.valid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst) begin
    if (sys_rst) begin
      sq <= '0;
    end else begin
      sq <= sd;
    end
  end

  assign word_o = sq.word;
  assign word_valid_o = sq.valid;
  assign phase_o = sq.phase;
  assign locked_o = sq.locked;
  assign overrun_o = sq.overrun;

endmodule

// >>> verif/dpa_rx_checker.sv
`timescale 1ns/1ps
module dpa_rx_checker (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic dynamic_phase_alignment_i,
  input wire logic word10_i,
  input wire logic word_ready_i,
  input wire dpa_rx_pkg::rx_word_t word_o,
  input wire logic word_valid_o,
  input wire dpa_rx_pkg::phase_t phase_o,
  input wire logic locked_o,
  input wire logic overrun_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_hold;
    word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled word changed");
  property p_narrow;
    word_valid_o && !word_o.wide |-> word_o.bits[9:8] == 2'h0;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("narrow word not zero extended");
  property p_width;
    word_valid_o |-> word_o.wide == $past(word10_i, 8);
  endproperty
  a_width: assert property (p_width)
    else $error("word width flag wrong");
  property p_fixed;
    !dynamic_phase_alignment_i [*8] |-> phase_o == 3'h0 && !locked_o;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("phase not fixed with alignment off");
  property p_sticky;
    overrun_o |=> overrun_o;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("overrun flag cleared");
  property p_ovr_full;
    $rose(overrun_o) |-> word_valid_o;
  endproperty
  a_ovr_full: assert property (p_ovr_full)
    else $error("overrun without held word");
  property p_lock_src;
    $rose(locked_o) |-> $past(dynamic_phase_alignment_i, 8);
  endproperty
  a_lock_src: assert property (p_lock_src)
    else $error("lock without alignment");
  property p_prime;
    $fell(rst_i) |-> !word_valid_o [*2];
  endproperty
  a_prime: assert property (p_prime)
    else $error("word before priming");
  property p_rst_out;
    $fell(rst_i) |-> !locked_o && !overrun_o && phase_o == 3'h0;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not clear after reset");
  c_lock: cover property ($rose(locked_o));
  c_take: cover property (word_valid_o && word_ready_i);
  c_ovr: cover property ($rose(overrun_o));
endmodule

// >>> verif/serial_tx_model.sv
`timescale 1ns/1ps
module serial_tx_model (
  input wire logic clk_link_i,
  input wire logic [19:0] pattern_i,
  input wire logic [4:0] len_i,
  input wire logic [2:0] skew_i,
  output logic [3:0] stage_true_o,
  output logic [3:0] stage_comp_o
);
  logic [4:0] idx = 5'h0;
  logic cur = 1'b0;
  logic prev = 1'b0;
  logic [7:0] taps;
  always @(posedge clk_link_i) begin
    prev <= cur;
    cur <= pattern_i[idx];
    idx <= (idx + 5'h1 >= len_i) ? 5'h0 : idx + 5'h1;
  end
  // Taps before the skew point still see the previous bit
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      taps[p] = (p < skew_i) ? prev : cur;
    end
  end
  assign stage_true_o = taps[3:0];
  assign stage_comp_o = taps[7:4];
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  num_errors++; $display("MISMATCH %0t got %0h exp %0h", $time, a, b); \
  end end
module testbench;
  logic clk_sys_i = 1'b0;
  logic clk_link_i = 1'b0;
  logic rst_i = 1'b1;
  logic dpa = 1'b0;
  logic w10 = 1'b0;
  logic rdy = 1'b1;
  logic [19:0] pat = 20'h00055;
  logic [4:0] len = 5'h08;
  logic [2:0] skew = 3'h0;
  logic [3:0] st;
  logic [3:0] sc;
  dpa_rx_pkg::rx_word_t word;
  dpa_rx_pkg::phase_t ph;
  logic vld;
  logic lck;
  logic ovr;
  int num_errors = 0;
  int total_checks = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  always #7.5 clk_link_i = ~clk_link_i;
  serial_tx_model serial_tx_model_inst (.clk_link_i(clk_link_i),
    .pattern_i(pat), .len_i(len), .skew_i(skew),
    .stage_true_o(st), .stage_comp_o(sc));
  dynamic_phase_align_rx dynamic_phase_align_rx_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_link_i(clk_link_i),
    .stage_true_i(st), .stage_comp_i(sc),
    .dynamic_phase_alignment_i(dpa), .word10_i(w10),
    .word_ready_i(rdy), .word_o(word), .word_valid_o(vld),
    .phase_o(ph), .locked_o(lck), .overrun_o(ovr));
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task do_reset;
    rst_i = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    rst_i = 1'b0;
  endtask
  task wait_on(input logic [2:0] exp);
    int n;
    n = 0;
    while ((lck !== 1'b1 || ph !== exp) && n < 600) begin
      @(negedge clk_sys_i);
      n++;
    end
    `CHK(lck, 1'b1);
    `CHK(ph, exp);
  endtask
  task t_reset_vals;
    do_reset;
    @(negedge clk_sys_i);
    `CHK({vld, lck, ovr, ph}, 6'h00);
  endtask
  task t_lock(input logic [19:0] p, input logic [4:0] l,
              input logic [2:0] s);
    pat = p;
    len = l;
    skew = s;
    dpa = 1'b1;
    do_reset;
    wait_on(s + 3'h4);
  endtask
  task t_track;
    skew = 3'h2;
    wait_on(3'h6);
  endtask
  task t_words(input logic j10);
    int n;
    n = 0;
    w10 = j10;
    t_lock(20'h00055, 5'h08, 3'h1);
    while (vld !== 1'b1 && n < 200) begin
      @(negedge clk_sys_i);
      n++;
    end
    `CHK(word.wide, j10);
    `CHK(word.bits == (j10 ? 10'h2AA : 10'h0AA) ||
      word.bits == (j10 ? 10'h155 : 10'h055), 1'b1);
  endtask
  task t_stall;
    rdy = 1'b0;
    repeat (60) @(negedge clk_sys_i);
    `CHK(ovr, 1'b1);
    `CHK(vld, 1'b1);
    rdy = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    `CHK(ovr, 1'b1);
  endtask
  task t_fixed;
    dpa = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    `CHK({lck, ph}, 4'h0);
    dpa = 1'b1;
    wait_on(3'h5);
  endtask
  initial begin
    @(negedge clk_sys_i);
    t_reset_vals;
    t_lock(20'h003FF, 5'h14, 3'h1);
    t_lock(20'h000F0, 5'h08, 3'h2);
    t_lock(20'h00009, 5'h08, 3'h3);
    t_lock(20'h00055, 5'h08, 3'h5);
    t_lock(20'h000AA, 5'h08, 3'h7);
    t_track;
    t_words(1'b1);
    t_words(1'b0);
    t_stall;
    t_fixed;
    end_of_test;
  end
  initial begin
    #1000000;
    num_errors++;
    end_of_test;
  end
endmodule
bind dynamic_phase_align_rx dpa_rx_checker dpa_rx_checker_inst (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .dynamic_phase_alignment_i(dynamic_phase_alignment_i),
  .word10_i(word10_i), .word_ready_i(word_ready_i), .word_o(word_o),
  .word_valid_o(word_valid_o), .phase_o(phase_o),
  .locked_o(locked_o), .overrun_o(overrun_o));
